// File: time_base_counters.sv
/*
 * Time base counters: an 8-bit clock timer with a high nibble read hold and
 * four falling-edge events, and a two-digit BCD stopwatch with overflow events.
 * Assumes a single-cycle strobed register port on the same clock, with read
 * data returned in the cycle after the read strobe.
 */

// Function
// RULE_01 - Clock timer count nibbles are read only; writes leave the count alone.
// RULE_02 - Reading the low nibble holds high carries until high read or window ends.
// RULE_03 - Reset clears all eight clock timer count bits.
// RULE_04 - Writing one to clock clear zeroes the count; bit reads zero.
// RULE_05 - Clock run bit starts on one, stops on zero, reads back, resets zero.
// RULE_06 - A stopped clock timer keeps its count and resumes from it.
// RULE_07 - Falling edges of 32, 8, 2, 1 Hz taps set flags regardless of mask.
// RULE_08 - Clock mask bits 0 to 3 enable interrupts, read back, reset zero.
// RULE_09 - Flags read one after event, writing one clears, reset to zero.
// RULE_10 - Software clears a serviced flag before re-enabling interrupts.
// RULE_11 - Software reads the low clock nibble before the high nibble.
// RULE_12 - Stopwatch is cascaded BCD hundredths and tenths digits.
// RULE_13 - Hundredths steps alternate 2 and 3 source periods; carry 25 or 26.
// RULE_14 - Tenths gets 25 and 26 period carries as 4 to 6; one second total.
// RULE_15 - Hundredths wrap sets the 10 Hz flag; tenths wrap sets 1 Hz flag.
// RULE_16 - Stopwatch flags are set regardless of stopwatch mask bits.
// RULE_17 - Stopwatch mask has 10 Hz enable bit 0, 1 Hz bit 1, upper zero.
// RULE_18 - Stopwatch control has write-only clear bit 1 and run bit 0.
// RULE_19 - Stopwatch digits are readable as two 4-bit registers.
// RULE_20 - Clock events happen on falling edges of the four counter taps.
// RULE_21 - Stopwatch clear zeroes both digits; runs on if running, else holds.
// RULE_22 - Stopwatch run starts on one, stops and keeps digits on zero.
// RULE_23 - Stopwatch digits are read only and reset to zero.
// RULE_24 - Each interrupt request is high while its flag and enable are both one.
module time_base_counters #(
   parameter int TICK_DIV = time_base_pkg::TICK_DIV,
   parameter int HOLD_CYC = time_base_pkg::HOLD_CYC
) (
   input wire logic CLK_IN,  // System clock, 250 MHz.
   input wire logic NRST_IN,  // Asynchronous reset, active low.
   input wire logic [15:0] ADDR_IN,  // Register address.
   input wire logic [3:0] WDATA_IN,  // Register write data.
   input wire logic WR_IN,  // Write strobe, one cycle.
   input wire logic RD_IN,  // Read strobe, one cycle.
   output logic [3:0] RDATA_OUT,  // Read data, valid the cycle after the strobe.
   output logic [3:0] CT_IRQ_OUT,  // Clock timer requests: 32, 8, 2, 1 Hz.
   output logic [1:0] SW_IRQ_OUT  // Stopwatch requests: 10 Hz, 1 Hz.
);

   // Source tick divider.
   logic [19:0] div_ff;
   logic tick_ff;
   // Clock timer state.
   logic ct_run_ff;
   logic [3:0] ct_low_ff;
   logic [3:0] ct_high_ff;
   logic [7:0] ct_prev_ff;
   logic hold_ff;
   logic [19:0] hold_cnt_ff;
   logic pend_ff;
   logic [3:0] ct_mask_ff;
   logic [3:0] ct_flag_ff;
   // Stopwatch state.
   logic sw_run_ff;
   logic [3:0] hund_ff;
   logic [3:0] tenth_ff;
   logic [1:0] phase_ff;
   logic [1:0] sw_mask_ff;
   logic [1:0] sw_flag_ff;

   // Decoded strobes and derived terms.
   logic ct_clr;
   logic sw_clr;
   logic rd_low;
   logic rd_high;
   logic carry_now;
   logic high_inc;
   logic [7:0] ct_count;
   logic [3:0] ct_fall;
   logic [1:0] step_last;
   logic sw_adv;
   logic hund_wrap;
   logic tenth_wrap;
   logic [3:0] nxt_rdata;

   // Strobe decode for the write-only clear bits and the ordered count reads.
   assign ct_clr = WR_IN && (ADDR_IN == time_base_pkg::CT_CTRL_ADDR)
                   && WDATA_IN[time_base_pkg::CLEAR_BIT];  // [RULE_04]
   assign sw_clr = WR_IN && (ADDR_IN == time_base_pkg::SW_CTRL_ADDR)
                   && WDATA_IN[time_base_pkg::CLEAR_BIT];  // [RULE_21]
   assign rd_low = RD_IN && (ADDR_IN == time_base_pkg::CT_LOW_ADDR);
   assign rd_high = RD_IN && (ADDR_IN == time_base_pkg::CT_HIGH_ADDR);

   // The divider turns the system clock into one pulse per 256 Hz period.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         div_ff <= 20'h0_0000;
         tick_ff <= 1'b0;
      end else if (div_ff == 20'(TICK_DIV - 1)) begin
         div_ff <= 20'h0_0000;
         tick_ff <= 1'b1;
      end else begin
         div_ff <= div_ff + 20'h0_0001;
         tick_ff <= 1'b0;
      end
   end

   // Run bits follow software writes; they start at stop.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ct_run_ff <= time_base_pkg::RUN_RESET;
         sw_run_ff <= time_base_pkg::RUN_RESET;
      end else if (WR_IN) begin
         if (ADDR_IN == time_base_pkg::CT_CTRL_ADDR) begin
            ct_run_ff <= WDATA_IN[time_base_pkg::RUN_BIT];  // [RULE_05]
         end
         if (ADDR_IN == time_base_pkg::SW_CTRL_ADDR) begin
            sw_run_ff <= WDATA_IN[time_base_pkg::RUN_BIT];  // [RULE_22]
         end
      end
   end

   // A carry out of the low nibble is held back while the read hold is open.
   assign carry_now = ct_run_ff && tick_ff && (ct_low_ff == 4'hf);
   assign high_inc = (carry_now || pend_ff) && !hold_ff;  // [RULE_02]
   assign ct_count = {ct_high_ff, ct_low_ff};

   // Low nibble counts source ticks while running; only a clock clear write touches it.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ct_low_ff <= time_base_pkg::NIBBLE_RESET;  // [RULE_03]
      end else if (ct_clr) begin
         ct_low_ff <= time_base_pkg::NIBBLE_RESET;  // [RULE_04]
      end else if (ct_run_ff && tick_ff) begin
         ct_low_ff <= ct_low_ff + 4'h1;  // [RULE_01] [RULE_06]
      end
   end

   // High nibble takes the carry at once, or on release of the hold.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ct_high_ff <= time_base_pkg::NIBBLE_RESET;  // [RULE_03]
      end else if (ct_clr) begin
         ct_high_ff <= time_base_pkg::NIBBLE_RESET;  // [RULE_04]
      end else if (high_inc) begin
         ct_high_ff <= ct_high_ff + 4'h1;  // [RULE_02]
      end
   end

   // The hold opens on a low read and closes on a high read or after the window.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         hold_ff <= 1'b0;
         hold_cnt_ff <= 20'h0_0000;
      end else if (ct_clr) begin
         hold_ff <= 1'b0;
         hold_cnt_ff <= 20'h0_0000;
      end else if (rd_low) begin
         hold_ff <= 1'b1;  // [RULE_02]
         hold_cnt_ff <= 20'h0_0000;
      end else if (rd_high || (hold_ff && hold_cnt_ff == 20'(HOLD_CYC - 1))) begin
         hold_ff <= 1'b0;  // [RULE_02]
         hold_cnt_ff <= 20'h0_0000;
      end else if (hold_ff) begin
         hold_cnt_ff <= hold_cnt_ff + 20'h0_0001;
      end
   end

   // A carry that arrives during the hold is kept so no time is lost.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         pend_ff <= 1'b0;
      end else if (ct_clr || !hold_ff) begin
         pend_ff <= 1'b0;
      end else if (carry_now) begin
         pend_ff <= 1'b1;  // [RULE_02]
      end
   end

   // The previous count is zeroed with the counter so a clear is not an edge.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ct_prev_ff <= 8'h00;
      end else if (ct_clr) begin
         ct_prev_ff <= 8'h00;
      end else begin
         ct_prev_ff <= ct_count;
      end
   end

   // Falling edges of the four interrupt taps.
   assign ct_fall[0] = ct_prev_ff[time_base_pkg::TAP_32HZ_BIT]
                       && !ct_count[time_base_pkg::TAP_32HZ_BIT];  // [RULE_20]
   assign ct_fall[1] = ct_prev_ff[time_base_pkg::TAP_8HZ_BIT]
                       && !ct_count[time_base_pkg::TAP_8HZ_BIT];  // [RULE_20]
   assign ct_fall[2] = ct_prev_ff[time_base_pkg::TAP_2HZ_BIT]
                       && !ct_count[time_base_pkg::TAP_2HZ_BIT];  // [RULE_20]
   assign ct_fall[3] = ct_prev_ff[time_base_pkg::TAP_1HZ_BIT]
                       && !ct_count[time_base_pkg::TAP_1HZ_BIT];  // [RULE_20]

   // Mask registers are plain read/write storage.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ct_mask_ff <= 4'h0;
         sw_mask_ff <= 2'h0;
      end else if (WR_IN) begin
         if (ADDR_IN == time_base_pkg::CT_MASK_ADDR) begin
            ct_mask_ff <= WDATA_IN;  // [RULE_08]
         end
         if (ADDR_IN == time_base_pkg::SW_MASK_ADDR) begin
            sw_mask_ff <= WDATA_IN[1:0];  // [RULE_17]
         end
      end
   end

   // Event flags: a new event wins over a write-one clear in the same cycle.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ct_flag_ff <= 4'h0;
      end else if (WR_IN && (ADDR_IN == time_base_pkg::CT_FLAG_ADDR)) begin
         ct_flag_ff <= (ct_flag_ff & ~WDATA_IN) | ct_fall;  // [RULE_09] [RULE_07]
      end else begin
         ct_flag_ff <= ct_flag_ff | ct_fall;  // [RULE_07]
      end
   end

   // Looks up whether the hundredths cycle of a tenths value is long.
   function automatic logic long_cycle(input logic [3:0] digit);
      long_cycle = time_base_pkg::LONG_CYCLE_MASK[digit];
   endfunction

   // Hundredths step length: odd digits take 3 periods, even 2, and digit 0
   // takes 3 in six of ten tenths so the second comes out to 256 periods.
   assign step_last = (hund_ff[0] || (hund_ff == 4'h0 && long_cycle(tenth_ff)))
                      ? 2'h2 : 2'h1;  // [RULE_13] [RULE_14]
   assign sw_adv = sw_run_ff && tick_ff && (phase_ff == step_last);
   assign hund_wrap = sw_adv && (hund_ff == time_base_pkg::BCD_MAX);
   assign tenth_wrap = hund_wrap && (tenth_ff == time_base_pkg::BCD_MAX);

   // Phase counts source ticks within one hundredths step.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         phase_ff <= 2'h0;
      end else if (sw_clr || sw_adv) begin
         phase_ff <= 2'h0;  // [RULE_21]
      end else if (sw_run_ff && tick_ff) begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   // The BCD digits cascade; the hundredths carry clocks the tenths digit.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         hund_ff <= time_base_pkg::NIBBLE_RESET;  // [RULE_23]
         tenth_ff <= time_base_pkg::NIBBLE_RESET;  // [RULE_23]
      end else if (sw_clr) begin
         hund_ff <= time_base_pkg::NIBBLE_RESET;  // [RULE_21]
         tenth_ff <= time_base_pkg::NIBBLE_RESET;  // [RULE_21]
      end else if (sw_adv) begin
         if (hund_wrap) begin
            hund_ff <= 4'h0;  // [RULE_12]
            tenth_ff <= tenth_wrap ? 4'h0 : tenth_ff + 4'h1;  // [RULE_12]
         end else begin
            hund_ff <= hund_ff + 4'h1;  // [RULE_12] [RULE_22]
         end
      end
   end

   // Stopwatch flags set on digit wraps whatever the mask holds.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         sw_flag_ff <= 2'h0;
      end else if (WR_IN && (ADDR_IN == time_base_pkg::SW_FLAG_ADDR)) begin
         sw_flag_ff <= (sw_flag_ff & ~WDATA_IN[1:0])
                       | {tenth_wrap, hund_wrap};  // [RULE_09] [RULE_15] [RULE_16]
      end else begin
         sw_flag_ff <= sw_flag_ff | {tenth_wrap, hund_wrap};  // [RULE_15] [RULE_16]
      end
   end

   // Interrupt requests are the registered product of flag and enable.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         CT_IRQ_OUT <= 4'h0;
         SW_IRQ_OUT <= 2'h0;
      end else begin
         CT_IRQ_OUT <= ct_flag_ff & ct_mask_ff;  // [RULE_24]
         SW_IRQ_OUT <= sw_flag_ff & sw_mask_ff;  // [RULE_24]
      end
   end

   // Read multiplexer; clear bits and unused bits read zero.
   always_comb begin
      nxt_rdata = 4'h0;
      unique case (ADDR_IN)
         time_base_pkg::CT_CTRL_ADDR: nxt_rdata = {3'h0, ct_run_ff};  // [RULE_04] [RULE_05]
         time_base_pkg::CT_LOW_ADDR: nxt_rdata = ct_low_ff;
         time_base_pkg::CT_HIGH_ADDR: nxt_rdata = ct_high_ff;
         time_base_pkg::SW_CTRL_ADDR: nxt_rdata = {3'h0, sw_run_ff};  // [RULE_18]
         time_base_pkg::SW_HUND_ADDR: nxt_rdata = hund_ff;  // [RULE_19]
         time_base_pkg::SW_TENTH_ADDR: nxt_rdata = tenth_ff;  // [RULE_19]
         time_base_pkg::CT_MASK_ADDR: nxt_rdata = ct_mask_ff;  // [RULE_08]
         time_base_pkg::SW_MASK_ADDR: nxt_rdata = {2'h0, sw_mask_ff};  // [RULE_17]
         time_base_pkg::CT_FLAG_ADDR: nxt_rdata = ct_flag_ff;
         time_base_pkg::SW_FLAG_ADDR: nxt_rdata = {2'h0, sw_flag_ff};
         default: nxt_rdata = 4'h0;
      endcase
   end

   // Read data stands for exactly the cycle after the strobe.
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         RDATA_OUT <= 4'h0;
      end else if (RD_IN) begin
         RDATA_OUT <= nxt_rdata;
      end else begin
         RDATA_OUT <= 4'h0;
      end
   end

   // Checks on the block's own behaviour.
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!NRST_IN);

   count_write_a: assert property ( // [RULE_01] [RULE_06]
      (!tick_ff && !ct_clr && !pend_ff) |=> $stable(ct_count))
      else $error("Clock count changed without a tick.");

   hold_freeze_a: assert property ( // [RULE_02]
      (hold_ff && carry_now && !rd_high && !ct_clr) |=> $stable(ct_high_ff) && pend_ff)
      else $error("High nibble advanced during hold.");

   hold_bound_a: assert property ( // [RULE_02]
      hold_ff |-> (hold_cnt_ff < 20'(HOLD_CYC)))
      else $error("Hold window overran.");

   ct_clear_a: assert property ( // [RULE_04]
      ct_clr |=> (ct_count == 8'h00) && !hold_ff)
      else $error("Clock clear did not zero the count.");

   ctrl_read_a: assert property ( // [RULE_04] [RULE_05]
      (RD_IN && ADDR_IN == time_base_pkg::CT_CTRL_ADDR) |=>
         (RDATA_OUT == {3'h0, $past(ct_run_ff)}) ##1 (RDATA_OUT == 4'h0 || $past(RD_IN)))
      else $error("Clock control readback wrong.");

   ct_event_a: assert property ( // [RULE_07] [RULE_20]
      ct_fall[0] |=> ct_flag_ff[0] ##1 CT_IRQ_OUT[0] == ct_mask_ff[0] || $past(WR_IN))
      else $error("32 Hz event not flagged.");

   flag_clear_a: assert property ( // [RULE_09]
      (WR_IN && ADDR_IN == time_base_pkg::CT_FLAG_ADDR && WDATA_IN[3] && !ct_fall[3])
         |=> !ct_flag_ff[3])
      else $error("Flag clear by write one failed.");

   bcd_range_a: assert property ( // [RULE_12] [RULE_23]
      (hund_ff <= time_base_pkg::BCD_MAX) && (tenth_ff <= time_base_pkg::BCD_MAX))
      else $error("Stopwatch digit out of range.");

   sw_wrap_a: assert property ( // [RULE_15] [RULE_16]
      tenth_wrap |=> sw_flag_ff == 2'h3 && hund_ff == 4'h0 && tenth_ff == 4'h0)
      else $error("Stopwatch wrap did not set flags.");

   sw_stop_a: assert property ( // [RULE_22]
      (!sw_run_ff && !sw_clr) |=> $stable(hund_ff) && $stable(tenth_ff))
      else $error("Stopped stopwatch moved.");

   irq_out_a: assert property ( // [RULE_24]
      ##1 (SW_IRQ_OUT == $past(sw_flag_ff & sw_mask_ff)))
      else $error("Stopwatch request does not follow flag and enable.");

   hold_release_c: cover property (hold_ff && carry_now ##[1:64] !hold_ff);
   ct_event_c: cover property (ct_fall[3]);
   sw_second_c: cover property (tenth_wrap);
   set_vs_clear_c: cover property (ct_fall[0] && WR_IN && ADDR_IN == time_base_pkg::CT_FLAG_ADDR);

endmodule

// File: time_base_counters_tb.sv
/*
 * Self-checking testbench for the time base counters: register access, clock
 * timer counting, read hold and events, stopwatch digits and events, resets.
 * Assumes the block's strobed register port and shortened tick and hold counts.
 */
module time_base_counters_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // Shortened counts so that a full second of ticks fits in a short run.
   localparam int TDIV = 8;
   localparam int HCYC = 40;
   localparam logic [15:0] CT_CTRL = time_base_pkg::CT_CTRL_ADDR;
   localparam logic [15:0] CT_LOW = time_base_pkg::CT_LOW_ADDR;
   localparam logic [15:0] CT_HIGH = time_base_pkg::CT_HIGH_ADDR;
   localparam logic [15:0] SW_CTRL = time_base_pkg::SW_CTRL_ADDR;
   localparam logic [15:0] SW_HUND = time_base_pkg::SW_HUND_ADDR;
   localparam logic [15:0] SW_TENTH = time_base_pkg::SW_TENTH_ADDR;
   localparam logic [15:0] CT_MASK = time_base_pkg::CT_MASK_ADDR;
   localparam logic [15:0] SW_MASK = time_base_pkg::SW_MASK_ADDR;
   localparam logic [15:0] CT_FLAG = time_base_pkg::CT_FLAG_ADDR;
   localparam logic [15:0] SW_FLAG = time_base_pkg::SW_FLAG_ADDR;

   logic CLK_IN;
   logic NRST_IN;
   logic [15:0] ADDR_IN;
   logic [3:0] WDATA_IN;
   logic WR_IN;
   logic RD_IN;
   logic [3:0] RDATA_OUT;
   logic [3:0] CT_IRQ_OUT;
   logic [1:0] SW_IRQ_OUT;
   int n_errors = 0;
   int checks_done = 0;
   int seed = 19;
   int sw_h;
   int sw_t;
   int sw_sub;
   int n;
   logic [7:0] ct_cnt;
   logic [3:0] ct_f;
   logic [1:0] sw_f;
   logic [3:0] m;
   logic [3:0] start;
   logic [15:0] addrs [10] = '{CT_CTRL, CT_LOW, CT_HIGH, SW_CTRL, SW_HUND, SW_TENTH,
                               CT_MASK, SW_MASK, CT_FLAG, SW_FLAG};
   int waits [2] = '{12, 60};

   time_base_counters #(.TICK_DIV(TDIV), .HOLD_CYC(HCYC)) dut (
      .CLK_IN(CLK_IN),
      .NRST_IN(NRST_IN),
      .ADDR_IN(ADDR_IN),
      .WDATA_IN(WDATA_IN),
      .WR_IN(WR_IN),
      .RD_IN(RD_IN),
      .RDATA_OUT(RDATA_OUT),
      .CT_IRQ_OUT(CT_IRQ_OUT),
      .SW_IRQ_OUT(SW_IRQ_OUT)
   );

   // The 250 MHz system clock.
   initial begin
      CLK_IN = 1'b0;
      forever #2 CLK_IN = ~CLK_IN;
   end

   // Counts a comparison and reports a mismatch at once.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // One write cycle; the strobe drops at the edge that samples it.
   task automatic wr(input logic [15:0] a, input logic [3:0] d);
      @(posedge CLK_IN);
      WR_IN <= 1'b1;
      ADDR_IN <= a;
      WDATA_IN <= d;
      @(posedge CLK_IN);
      WR_IN <= 1'b0;
   endtask

   // One read cycle; read data are taken in the cycle after the strobe.
   task automatic rd_chk(input logic [15:0] a, input logic [3:0] exp);
      @(posedge CLK_IN);
      RD_IN <= 1'b1;
      ADDR_IN <= a;
      @(posedge CLK_IN);
      RD_IN <= 1'b0;
      #1;
      check({4'h0, RDATA_OUT}, {4'h0, exp});
   endtask

   // Runs a counter for exactly cyc clock edges, then stops it.
   task automatic run_for(input logic [15:0] a, input logic [3:0] st, input int cyc);
      wr(a, st);
      repeat (cyc - 2) @(posedge CLK_IN);
      wr(a, 4'h0);
   endtask

   // Holds reset low for two cycles.
   task automatic do_reset();
      NRST_IN <= 1'b0;
      repeat (2) @(posedge CLK_IN);
      NRST_IN <= 1'b1;
   endtask

   // Expected clock timer count and tap falling-edge events after n ticks.
   function automatic void ct_adv(input int ticks);
      for (int i = 0; i < ticks; i++) begin
         logic [7:0] nx;
         nx = ct_cnt + 8'h01;
         ct_f[0] |= ct_cnt[time_base_pkg::TAP_32HZ_BIT] & ~nx[time_base_pkg::TAP_32HZ_BIT];
         ct_f[1] |= ct_cnt[time_base_pkg::TAP_8HZ_BIT] & ~nx[time_base_pkg::TAP_8HZ_BIT];
         ct_f[2] |= ct_cnt[time_base_pkg::TAP_2HZ_BIT] & ~nx[time_base_pkg::TAP_2HZ_BIT];
         ct_f[3] |= ct_cnt[time_base_pkg::TAP_1HZ_BIT] & ~nx[time_base_pkg::TAP_1HZ_BIT];
         ct_cnt = nx;
      end
   endfunction

   // Expected stopwatch digits and overflow events after n ticks of 256 Hz.
   function automatic void sw_adv(input int ticks);
      for (int i = 0; i < ticks; i++) begin
         sw_sub++;
         if (sw_sub == ((sw_h % 2 == 1 || (sw_h == 0 && time_base_pkg::LONG_CYCLE_MASK[sw_t]))
               ? 3 : 2)) begin
            sw_sub = 0;
            if (sw_h == 9) begin
               sw_h = 0;
               sw_f[0] = 1'b1;
               sw_f[1] = sw_f[1] | (sw_t == 9);
               sw_t = (sw_t + 1) % 10;
            end else begin
               sw_h++;
            end
         end
      end
   endfunction

   // Aborts a hung run well after the expected length of the tests.
   initial begin
      repeat (60000) @(posedge CLK_IN);
      n_errors++;
      $display("Watchdog expired");
      close_out();
   end

   // Main sequence of tests.
   initial begin
      NRST_IN = 1'b0;
      ADDR_IN = 16'h0000;
      WDATA_IN = 4'h0;
      WR_IN = 1'b0;
      RD_IN = 1'b0;
      do_reset();
      foreach (addrs[k]) rd_chk(addrs[k], 4'h0);
      // Masks, control bits and an unmapped address.
      for (int k = 0; k < 3; k++) begin
         m = 4'($random(seed));
         wr(CT_MASK, m);
         rd_chk(CT_MASK, m);
         wr(SW_MASK, m);
         rd_chk(SW_MASK, {2'b00, m[1:0]});
         wr(16'hff7b, m);
         rd_chk(16'hff7b, 4'h0);
      end
      for (int k = 0; k < 2; k++) begin
         wr(k ? SW_CTRL : CT_CTRL, 4'hf);
         rd_chk(k ? SW_CTRL : CT_CTRL, 4'h1);
         wr(k ? SW_CTRL : CT_CTRL, 4'h2);
         rd_chk(k ? SW_CTRL : CT_CTRL, 4'h0);
      end
      $display("Register access test finished");
      // Counting windows from clear, plus one resumed window without clear.
      for (int i = 0; i < 5; i++) begin
         n = (i == 0) ? 25 : (i == 1) ? 256 : (($random(seed) & 255) + 2);
         start = (i == 3) ? 4'h1 : 4'h3;
         if (start == 4'h3) begin
            ct_cnt = 8'h00;
            sw_h = 0;
            sw_t = 0;
            sw_sub = 0;
         end
         m = 4'($random(seed));
         ct_f = 4'h0;
         sw_f = 2'b00;
         wr(CT_MASK, m);
         wr(SW_MASK, m);
         wr(CT_FLAG, 4'hf);
         wr(SW_FLAG, 4'h3);
         run_for(CT_CTRL, start, n * TDIV);
         run_for(SW_CTRL, start, n * TDIV);
         ct_adv(n);
         sw_adv(n);
         wr(CT_LOW, m);
         wr(CT_HIGH, ~m);
         wr(SW_HUND, m);
         wr(SW_TENTH, ~m);
         rd_chk(CT_LOW, ct_cnt[3:0]);
         rd_chk(CT_HIGH, ct_cnt[7:4]);
         rd_chk(SW_HUND, 4'(sw_h));
         rd_chk(SW_TENTH, 4'(sw_t));
         rd_chk(CT_FLAG, ct_f);
         rd_chk(SW_FLAG, {2'b00, sw_f});
         check({4'h0, CT_IRQ_OUT}, {4'h0, ct_f & m});
         check({6'h00, SW_IRQ_OUT}, {6'h00, sw_f & m[1:0]});
         wr(CT_FLAG, 4'h0);
         wr(SW_FLAG, ~m);
         rd_chk(CT_FLAG, ct_f);
         rd_chk(SW_FLAG, {2'b00, sw_f & m[1:0]});
         $display("Counting window %0d of %0d ticks finished", i, n);
      end
      // Low read holds the high carry until the high read or the window ends.
      for (int k = 0; k < 2; k++) begin
         run_for(CT_CTRL, 4'h3, 15 * TDIV);
         rd_chk(CT_LOW, 4'hf);
         wr(CT_CTRL, 4'h1);
         repeat (waits[k]) @(posedge CLK_IN);
         rd_chk(CT_HIGH, 4'(k));
         wr(CT_CTRL, 4'h0);
         rd_chk(CT_HIGH, 4'h1);
      end
      $display("Read hold test finished");
      // Reset in mid-run with flags, masks and counts all nonzero.
      wr(CT_MASK, 4'hf);
      wr(SW_MASK, 4'h3);
      wr(CT_CTRL, 4'h1);
      wr(SW_CTRL, 4'h1);
      repeat (400) @(posedge CLK_IN);
      do_reset();
      foreach (addrs[k]) rd_chk(addrs[k], 4'h0);
      check({2'b00, SW_IRQ_OUT, CT_IRQ_OUT}, 8'h00);
      $display("Mid-run reset test finished");
      close_out();
   end
endmodule

// File: time_base_pkg.sv
/*
 * Constants shared by the time base counter block: register addresses, bit
 * positions, reset values and timing counts for the clock timer and stopwatch.
 * Assumes a 250 MHz system clock and a 16-bit I/O address space.
 */
package time_base_pkg;

   // Register addresses on the I/O bus.
   localparam logic [15:0] CT_CTRL_ADDR = 16'hff78;
   localparam logic [15:0] CT_LOW_ADDR = 16'hff79;
   localparam logic [15:0] CT_HIGH_ADDR = 16'hff7a;
   localparam logic [15:0] SW_CTRL_ADDR = 16'hff7c;
   localparam logic [15:0] SW_HUND_ADDR = 16'hff7d;
   localparam logic [15:0] SW_TENTH_ADDR = 16'hff7e;
   localparam logic [15:0] CT_MASK_ADDR = 16'hffe6;
   localparam logic [15:0] SW_MASK_ADDR = 16'hffe7;
   localparam logic [15:0] CT_FLAG_ADDR = 16'hfff6;
   localparam logic [15:0] SW_FLAG_ADDR = 16'hfff7;

   // Control register fields, shared by both control registers.
   localparam int RUN_BIT = 0;
   localparam int CLEAR_BIT = 1;

   // Counter taps whose falling edges raise clock timer events.
   localparam int TAP_32HZ_BIT = 2;
   localparam int TAP_8HZ_BIT = 4;
   localparam int TAP_2HZ_BIT = 6;
   localparam int TAP_1HZ_BIT = 7;

   // Reset values.
   localparam logic [3:0] NIBBLE_RESET = 4'h0;
   localparam logic RUN_RESET = 1'b0;

   // Largest decimal digit value.
   localparam logic [3:0] BCD_MAX = 4'h9;

   // Tenths digits whose hundredths cycle lasts 26 source periods (six of ten).
   localparam logic [15:0] LONG_CYCLE_MASK = 16'h02d6;

   // Clock rate and the 256 Hz source tick derived from it.
   localparam int CLK_KHZ = 250000;
   localparam int TICK_HZ = 256;
   localparam int TICK_DIV = (CLK_KHZ * 1000) / TICK_HZ;

   // High nibble hold window, shortest documented figure in microseconds.
   localparam int HOLD_US = 480;
   localparam int HOLD_CYC = (HOLD_US * CLK_KHZ + 999) / 1000;

endpackage
